/* rtl/ect_pkg.sv */
// event capture timer: shared register map, field positions, modes and reset values
// assumes a 32-bit apb slave with word-aligned registers
package ect_pkg;
   // register byte offsets
   localparam logic [7:0] ECT_CONTROL_A_OFS   = 8'h00;     // control_a: enable, clock select
   localparam logic [7:0] ECT_CTRLB_OFS   = 8'h04;     // mode, output init level
   localparam logic [7:0] ECT_EVCTRL_OFS  = 8'h08;     // event enable, edge, filter
   localparam logic [7:0] ECT_INTCTRL_OFS = 8'h0C;     // capture interrupt enable
   localparam logic [7:0] ECT_INTFLG_OFS  = 8'h10;     // capture_flag, write one to clear
   localparam logic [7:0] ECT_STATUS_OFS  = 8'h14;     // running bit, read only
   localparam logic [7:0] ECT_DEBUG_CONTROL_OFS = 8'h18;     // debug_control: run_in_debug
   localparam logic [7:0] ECT_CNT_OFS     = 8'h1C;     // count_value
   localparam logic [7:0] ECT_CAPTURE_COMPARE_VALUE_OFS    = 8'h20;     // capture_compare_value
   // field positions
   localparam int ECT_EN_BIT     = 0;
   localparam int ECT_CKSEL_LSB  = 1;
   localparam int ECT_CKSEL_W    = 3;
   localparam int ECT_MODE_LSB   = 0;
   localparam int ECT_MODE_W     = 3;
   localparam int ECT_WOINIT_BIT = 4;
   localparam int ECT_CAPTURE_EVENT_INPUT_ENABLE_BIT = 0;
   localparam int ECT_EDGE_BIT   = 4;
   localparam int ECT_FILT_BIT   = 6;
   localparam int ECT_CAPTURE_FLAG_BIT   = 0;
   localparam int ECT_RUN_BIT    = 0;
   localparam int ECT_RUN_IN_DEBUG_BIT = 0;
   // clock select code that takes the companion_timer prescaled tick
   localparam logic [2:0] ECT_CKSEL_COMP = 3'h7;
   // sizes and reset values
   localparam int          ECT_CNT_W     = 16;
   localparam int          ECT_FILT_LEN  = 4;
   localparam logic [15:0] ECT_CNT_RST   = 16'h0000;
   localparam logic [15:0] ECT_CAPTURE_COMPARE_VALUE_RST  = 16'h0000;
   // the eight operating modes
   typedef enum logic [2:0] {
      ECT_M_PERIODIC = 3'h0,
      ECT_M_TIMEOUT  = 3'h1,
      ECT_M_CAPEVT   = 3'h2,
      ECT_M_FREQ     = 3'h3,
      ECT_M_PW       = 3'h4,
      ECT_M_FRQPW    = 3'h5,
      ECT_M_SINGLE   = 3'h6,
      ECT_M_PWM8     = 3'h7
   } ect_mode_t;
   // time-out check states, gray along idle -> measure -> freeze
   typedef enum logic [1:0] {
      ECT_TO_IDLE = 2'b00,
      ECT_TO_MEAS = 2'b01,
      ECT_TO_FRZ  = 2'b11
   } ect_to_state_t;
endpackage

/* rtl/ect_prescaler.sv */
// event capture timer: count tick generator
// assumes the companion timer tick is a one-cycle pulse in the pclk domain
`timescale 1ns/1ps
module ect_prescaler
   import ect_pkg::*;
#(
   parameter int PRE_W = 7                  // width of the local divider
)(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [2:0] clock_source_select,
   input  wire logic       companion_tick,
   output logic            tick
);
   logic [PRE_W-1:0] pre_q;                 // free-running divider
   logic [PRE_W-1:0] mask;                  // low bits that must all be ones

   // divider runs always so the tick phase never depends on enable
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pre_q <= '0;
      end
      else
      begin
         pre_q <= pre_q + 1'b1;
      end
   end

   // divide by two to the power of the select code, or borrow the companion tick
   always_comb
   begin
      mask = PRE_W'((1 << clock_source_select) - 1);
      if (clock_source_select == ECT_CKSEL_COMP)
      begin
         tick = companion_tick;
      end
      else
      begin
         tick = &(pre_q | ~mask);
      end
   end
endmodule

/* rtl/ect_noise_filter.sv */
// event capture timer: event input noise canceler
// assumes the event level is synchronous to pclk; runs on undivided pclk
`timescale 1ns/1ps
module ect_noise_filter
   import ect_pkg::*;
#(
   parameter int LEN = ECT_FILT_LEN         // samples that must agree
)(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic filt_en,
   input  wire logic event_in,
   output logic      level_q
);
   logic [LEN-1:0] samp_q;                  // last samples, newest in bit 0

   // sampling is on pclk itself, the prescaler never slows it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         samp_q  <= '0;
         level_q <= 1'b0;
      end
      else
      begin
         samp_q <= {samp_q[LEN-2:0], event_in};
         if (!filt_en)
         begin
            level_q <= event_in;            // plain one-stage pass
         end
         else if (&samp_q)
         begin
            level_q <= 1'b1;                // stable high
         end
         else if (~|samp_q)
         begin
            level_q <= 1'b0;                // stable low
         end
      end
   end
endmodule

/* rtl/ect_timer.sv */
// event capture timer: 16-bit timer with capture modes, apb register file
// assumes apb3 master on pclk, event input and debug halt synchronous to pclk
//
// Function
// - filter forwards level after four agreeing samples
// - filter adds exactly four cycles latency
// - filter samples on undivided pclk
// - count from local prescaler or companion tick
// - one of eight modes selectable
// - debug halt stops timer unless run_in_debug
// - reset mode is periodic interrupt
// - enable starts counting at selected rate
// - periodic: count to top, flag, restart
// - periodic: top below count wraps silently
// - time-out: first edge restarts, second stops
// - time-out: flag if top before second edge
// - freeze: new edge restarts, count writes still taken
// - capture on event: copy count, flag
// - edge polarity selectable rising or falling
// - capture read of upper byte clears flag
// - frequency: capture, restart, flag per edge
// - frequency: upper byte read clears flag
// - detect bottom, max and top conditions
// - every flag set strobes event output
// - events act only with input enable set
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module ect_timer
   import ect_pkg::*;
#(
   parameter int CW = ECT_CNT_W             // counter width
)(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        event_in,
   input  wire logic        companion_tick,
   input  wire logic        debug_halt,
   output logic             event_out,
   output logic             irq,
   output logic             waveform_output
);
   // software registers
   logic          enable_q;                 // control_a enable
   logic [2:0]    cksel_q;                  // clock_source_select
   ect_mode_t     mode_q;                   // operating mode
   logic          wo_init_q;                // idle output level
   logic          capture_event_input_enable_q;                 // capture_event_input_enable
   logic          edge_q;                   // 1 selects falling edge
   logic          filt_q;                   // noise canceler on
   logic          inten_q;                  // capture interrupt enable
   logic          flag_q;                   // capture_flag
   logic          run_in_debug_q;                 // run_in_debug
   logic [CW-1:0] cnt_q;                    // count_value
   logic [CW-1:0] capture_compare_value_q;                   // capture_compare_value
   ect_to_state_t to_q;                     // time-out check state
   logic          filt_lvl;                 // filtered event level
   logic          lvl_prev_q;               // previous filtered level
   logic          tick;                     // prescaled count tick
   logic          active;                   // enabled and not halted
   logic          cnt_step;                 // counter advances this cycle
   logic          evt;                      // qualified event edge
   logic          flag_set;                 // any flag-setting condition
   logic          at_bottom;                // count is zero
   logic          at_max;                   // count is all ones
   logic          at_top;                   // count equals compare value
   logic          wr;                       // apb write access phase
   logic          rd;                       // apb read access phase
   logic          hit;                      // address maps to a register
   logic          cnt_run;                  // mode lets counter run

   // bus decode; zero wait states
   assign wr     = psel & penable & pwrite;
   assign rd     = psel & penable & ~pwrite;
   assign pready = 1'b1;

   ect_prescaler u_pre (
      .pclk                (pclk),
      .presetn             (presetn),
      .clock_source_select (cksel_q),
      .companion_tick      (companion_tick),
      .tick                (tick)
   );

   ect_noise_filter u_filt (
      .pclk     (pclk),
      .presetn  (presetn),
      .filt_en  (filt_q),
      .event_in (event_in),
      .level_q  (filt_lvl)
   );

   // halting in debug also masks events, so nothing moves while frozen
   assign active    = enable_q & (~debug_halt | run_in_debug_q);
   assign cnt_run   = (mode_q != ECT_M_TIMEOUT) | (to_q != ECT_TO_FRZ);
   assign cnt_step  = active & tick & cnt_run;
   assign at_bottom = (cnt_q == '0);
   assign at_max    = &cnt_q;
   assign at_top    = (cnt_q == capture_compare_value_q);

   // edge detect on filtered level; polarity chosen by edge_q
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lvl_prev_q <= 1'b0;
      end
      else
      begin
         lvl_prev_q <= filt_lvl;
      end
   end
   assign evt = active & capture_event_input_enable_q &
                (edge_q ? (lvl_prev_q & ~filt_lvl)
                        : (~lvl_prev_q & filt_lvl));

   // sources of the capture flag, per mode
   always_comb
   begin
      case (mode_q)
         ECT_M_PERIODIC: flag_set = cnt_step & at_top;
         ECT_M_TIMEOUT:  flag_set = cnt_step & at_top & (to_q == ECT_TO_MEAS);
         ECT_M_CAPEVT:   flag_set = evt;
         ECT_M_FREQ:     flag_set = evt;
         default:        flag_set = 1'b0;   // later modes not built here
      endcase
   end

   // control registers; reset leaves periodic mode selected
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         enable_q  <= 1'b0;
         cksel_q   <= 3'h0;
         mode_q    <= ECT_M_PERIODIC;
         wo_init_q <= 1'b0;
         capture_event_input_enable_q  <= 1'b0;
         edge_q    <= 1'b0;
         filt_q    <= 1'b0;
         inten_q   <= 1'b0;
         run_in_debug_q  <= 1'b0;
      end
      else if (wr)
      begin
         case (paddr)
            ECT_CONTROL_A_OFS:
            begin
               enable_q <= pwdata[ECT_EN_BIT];
               cksel_q  <= pwdata[ECT_CKSEL_LSB +: ECT_CKSEL_W];
            end
            ECT_CTRLB_OFS:
            begin
               mode_q    <= ect_mode_t'(pwdata[ECT_MODE_LSB +: ECT_MODE_W]);
               wo_init_q <= pwdata[ECT_WOINIT_BIT];
            end
            ECT_EVCTRL_OFS:
            begin
               capture_event_input_enable_q <= pwdata[ECT_CAPTURE_EVENT_INPUT_ENABLE_BIT];
               edge_q   <= pwdata[ECT_EDGE_BIT];
               filt_q   <= pwdata[ECT_FILT_BIT];
            end
            ECT_INTCTRL_OFS: inten_q  <= pwdata[ECT_CAPTURE_FLAG_BIT];
            ECT_DEBUG_CONTROL_OFS: run_in_debug_q <= pwdata[ECT_RUN_IN_DEBUG_BIT];
            default:         ;              // other offsets hold no control
         endcase
      end
   end

   // capture flag: a set in the same cycle as any clear wins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flag_q <= 1'b0;
      end
      else if (flag_set)
      begin
         flag_q <= 1'b1;
      end
      else if (wr && paddr == ECT_INTFLG_OFS && pwdata[ECT_CAPTURE_FLAG_BIT])
      begin
         flag_q <= 1'b0;                    // write one to clear
      end
      else if (rd && paddr == ECT_CAPTURE_COMPARE_VALUE_OFS &&
               (mode_q == ECT_M_CAPEVT || mode_q == ECT_M_FREQ))
      begin
         flag_q <= 1'b0;
      end
   end

   // time-out check sequencer: restart on first edge, freeze on second
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         to_q <= ECT_TO_IDLE;
      end
      else if (mode_q != ECT_M_TIMEOUT || !enable_q)
      begin
         to_q <= ECT_TO_IDLE;
      end
      else if (evt)
      begin
         case (to_q)
            ECT_TO_IDLE: to_q <= ECT_TO_MEAS;
            ECT_TO_MEAS: to_q <= ECT_TO_FRZ;
            ECT_TO_FRZ:  to_q <= ECT_TO_MEAS;
            default:     to_q <= ECT_TO_IDLE;
         endcase
      end
   end

   // counter; a software write beats any hardware update
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_q <= ECT_CNT_RST;
      end
      else if (wr && paddr == ECT_CNT_OFS)
      begin
         cnt_q <= pwdata[CW-1:0];
      end
      else if (evt && (mode_q == ECT_M_FREQ ||
               (mode_q == ECT_M_TIMEOUT && to_q != ECT_TO_MEAS)))
      begin
         cnt_q <= '0;
      end
      else if (cnt_step)
      begin
         if ((mode_q == ECT_M_PERIODIC && at_top) || at_max)
         begin
            cnt_q <= '0;
         end
         else
         begin
            cnt_q <= cnt_q + 1'b1;          // plain up count below max
         end
      end
   end

   // compare/capture register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         capture_compare_value_q <= ECT_CAPTURE_COMPARE_VALUE_RST;
      end
      else if (wr && paddr == ECT_CAPTURE_COMPARE_VALUE_OFS)
      begin
         capture_compare_value_q <= pwdata[CW-1:0];
      end
      else if (evt && (mode_q == ECT_M_CAPEVT || mode_q == ECT_M_FREQ))
      begin
         capture_compare_value_q <= cnt_q;
      end
   end

   // outputs: event strobe registered at the same edge as the flag sets, idle waveform level
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         event_out       <= 1'b0;
         waveform_output <= 1'b0;
      end
      else
      begin
         event_out       <= flag_set;
         waveform_output <= wo_init_q;
      end
   end
   assign irq = flag_q & inten_q;

   // read mux; unmapped addresses read zero and report an error
   always_comb
   begin
      hit    = 1'b1;
      prdata = 32'h0000_0000;
      case (paddr)
         ECT_CONTROL_A_OFS:   prdata = {28'h0, cksel_q, enable_q};
         ECT_CTRLB_OFS:   prdata = {27'h0, wo_init_q, 1'b0, mode_q};
         ECT_EVCTRL_OFS:  prdata = {25'h0, filt_q, 1'b0, edge_q, 3'h0, capture_event_input_enable_q};
         ECT_INTCTRL_OFS: prdata = {31'h0, inten_q};
         ECT_INTFLG_OFS:  prdata = {31'h0, flag_q};
         ECT_STATUS_OFS:  prdata = {31'h0, enable_q & cnt_run};
         ECT_DEBUG_CONTROL_OFS: prdata = {31'h0, run_in_debug_q};
         ECT_CNT_OFS:     prdata = {16'h0, cnt_q};
         ECT_CAPTURE_COMPARE_VALUE_OFS:    prdata = {16'h0, capture_compare_value_q};
         default:         hit    = 1'b0;
      endcase
      if (!rd)
      begin
         prdata = 32'h0000_0000;
      end
   end
   assign pslverr = psel & penable & ~hit;

   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   filter_latency_a: assert property (
      $past(filt_q, 6) && filt_q && $changed(filt_lvl) |->
      ($past(event_in, 2) == filt_lvl) && ($past(event_in, 5) == filt_lvl))
      else $error("filtered level changed without four agreeing samples");
   period_wrap_a: assert property (
      mode_q == ECT_M_PERIODIC && cnt_step && at_top && !wr |=> cnt_q == '0 && flag_q)
      else $error("periodic top did not restart and flag");
   above_top_a: assert property (
      mode_q == ECT_M_PERIODIC && cnt_step && cnt_q > capture_compare_value_q && !at_max && !wr |=>
      cnt_q == $past(cnt_q) + 1'b1 && !$rose(flag_q))
      else $error("periodic count above top did not run on quietly");
   capture_copy_a: assert property (
      mode_q == ECT_M_CAPEVT && evt && !wr |=> capture_compare_value_q == $past(cnt_q) && flag_q)
      else $error("capture did not copy count");
   freq_restart_a: assert property (
      mode_q == ECT_M_FREQ && evt && !wr |=> cnt_q == '0 && capture_compare_value_q == $past(cnt_q))
      else $error("frequency edge did not capture and restart");
   debug_stop_a: assert property (
      debug_halt && !run_in_debug_q && !wr |=> $stable(cnt_q) && !$rose(flag_q))
      else $error("timer moved while halted");
   timeout_top_a: assert property (
      mode_q == ECT_M_TIMEOUT && to_q == ECT_TO_MEAS && at_top && cnt_step |=> flag_q)
      else $error("time-out top missed");
   freeze_hold_a: assert property (
      to_q == ECT_TO_FRZ && mode_q == ECT_M_TIMEOUT && !evt && !wr |=> $stable(cnt_q))
      else $error("counter moved in freeze");
   strobe_pulse_a: assert property (
      flag_set |=> event_out ##1 (!event_out || $past(flag_set)))
      else $error("event strobe missing or stretched");
   no_event_a: assert property (
      (mode_q == ECT_M_CAPEVT || mode_q == ECT_M_FREQ) && !capture_event_input_enable_q && !wr |=>
      $stable(capture_compare_value_q) && !$rose(flag_q))
      else $error("event acted on while input disabled");
   wrap_bottom_a: assert property (
      cnt_step && at_max && !wr && !evt |=> at_bottom)
      else $error("count did not wrap from max to bottom");

   periodic_c: cover property (mode_q == ECT_M_PERIODIC && flag_set);
   capture_c:  cover property (mode_q == ECT_M_CAPEVT && evt ##[1:50] rd);
   freq_c:     cover property (mode_q == ECT_M_FREQ && evt ##[1:200] evt);
   freeze_c:   cover property (to_q == ECT_TO_MEAS ##[1:200] to_q == ECT_TO_FRZ);
endmodule

/* tb/ect_event_src.sv */
// event capture timer bench: event channel and companion timer tick model
// assumes pulse requests come as one-cycle strobes on pclk
`timescale 1ns/1ps
module ect_event_src (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       fire,            // start one pulse
   input  wire logic [3:0] len,             // pulse length in cycles
   input  wire logic       base,            // resting level of the channel
   input  wire logic       tick_en,         // companion timer running
   output logic            event_in,
   output logic            companion_tick
);
   logic [3:0] left_q;                      // cycles left in current pulse
   logic [1:0] div_q;                       // companion divider
   // pulse length counter; never below two cycles or an edge may be lost
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         left_q <= 4'h0;
      else if (fire)
         left_q <= (len < 4'h2) ? 4'h2 : len;
      else if (left_q != 4'h0)
         left_q <= left_q - 4'h1;
   end
   // pulse inverts the resting level
   assign event_in = base ^ (left_q != 4'h0);
   // companion tick every fourth cycle while its timer runs
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         div_q <= 2'h0;
      else
         div_q <= tick_en ? div_q + 2'h1 : 2'h0;
   end
   assign companion_tick = tick_en && (div_q == 2'h3);
endmodule

/* tb/ect_timer_tb.sv */
// event capture timer bench: apb driven sequences with expected values
// assumes the event model drives the event input and companion tick
`timescale 1ns/1ps
module ect_timer_tb
   import ect_pkg::*;
;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        debug_halt = 1'b0;
   logic        fire = 1'b0;              // pulse request to event model
   logic [3:0]  len = 4'h4;
   logic        base = 1'b0;
   logic        tick_en = 1'b0;
   logic [31:0] prdata, rdv, a, b;        // rdv holds last read word
   logic        pready, pslverr, se, event_in, companion_tick, event_out, irq;
   logic        waveform_output, ev_prev = 1'b0;
   int          err_total = 0, compares = 0, cyc = 0, ev_cnt = 0;
   int          t_rise = 0, t_out = 0, lat0 = 0;
   always #20 pclk = ~pclk;
   ect_timer i_ect_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .event_in(event_in), .companion_tick(companion_tick),
      .debug_halt(debug_halt), .event_out(event_out), .irq(irq),
      .waveform_output(waveform_output));
   ect_event_src i_ect_event_src (.pclk(pclk), .presetn(presetn), .fire(fire), .len(len),
      .base(base), .tick_en(tick_en), .event_in(event_in), .companion_tick(companion_tick));
   // edge and strobe timing monitor, plus the hang limit
   always @(posedge pclk)
   begin
      if (event_in && !ev_prev)
         t_rise = cyc;
      if (event_out === 1'b1)
      begin
         ev_cnt++;
         t_out = cyc;
      end
      ev_prev = event_in;
      cyc++;
      if (cyc == 20000)
      begin
         err_total++;
         complete_run();
      end
   end
   // one apb transfer; waits for pready, samples answer at that edge
   task xfer(input logic w, input logic [7:0] ad, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rdv = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] ad, input logic [31:0] d);
      xfer(1'b1, ad, d);
   endtask
   task rd(input logic [7:0] ad);
      xfer(1'b0, ad, 32'h0);
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         err_total++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task flag_is(input logic e);
      rd(ECT_INTFLG_OFS);
      chk("capture_flag", {31'h0, e}, rdv);
   endtask
   // one event pulse, then time for filter, capture and strobe
   task pulse(input logic [3:0] n);
      fire <= 1'b1;
      len <= n;
      @(posedge pclk);
      fire <= 1'b0;
      repeat (14) @(posedge pclk);
   endtask
   task complete_run;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rd(ECT_CTRLB_OFS);
      chk("mode_after_reset", 32'h0, rdv);
      rd(8'h30);
      chk("unmapped_error", 32'h1, {31'h0, se});
      for (int m = 0; m < 8; m++)
      begin
         wr(ECT_CTRLB_OFS, 32'(m));
         rd(ECT_CTRLB_OFS);
         chk("mode_select", 32'(m), rdv);
      end
      wr(ECT_CTRLB_OFS, 32'h10);
      repeat (2) @(posedge pclk);
      chk("waveform_output", 32'h1, {31'h0, waveform_output});
      // periodic: top of five, counter must restart at it, never pass it
      wr(ECT_CAPTURE_COMPARE_VALUE_OFS, 32'h5);
      wr(ECT_INTCTRL_OFS, 32'h1);
      wr(ECT_CONTROL_A_OFS, 32'h1);
      repeat (12) @(posedge pclk);
      chk("irq", 32'h1, {31'h0, irq});
      rd(ECT_CNT_OFS);
      chk("count_within_top", 32'h1, {31'h0, rdv <= 32'h5});
      // top below count: runs on with no flag
      wr(ECT_CONTROL_A_OFS, 32'h0);
      wr(ECT_CNT_OFS, 32'h64);
      wr(ECT_INTFLG_OFS, 32'h1);
      wr(ECT_CONTROL_A_OFS, 32'h1);
      repeat (100) @(posedge pclk);
      flag_is(1'b0);
      rd(ECT_CNT_OFS);
      chk("count_past_top", 32'h1, {31'h0, rdv > 32'h64});
      // debug halt, then run in debug
      debug_halt <= 1'b1;
      rd(ECT_CNT_OFS);
      a = rdv;
      rd(ECT_CNT_OFS);
      chk("count_halted", a, rdv);
      wr(ECT_DEBUG_CONTROL_OFS, 32'h1);
      rd(ECT_CNT_OFS);
      a = rdv;
      rd(ECT_CNT_OFS);
      chk("count_in_debug", 32'h1, {31'h0, rdv != a});
      debug_halt <= 1'b0;
      // capture on event, input disabled first
      wr(ECT_CONTROL_A_OFS, 32'h0);
      wr(ECT_CNT_OFS, 32'h0);
      wr(ECT_CTRLB_OFS, 32'h2);
      wr(ECT_EVCTRL_OFS, 32'h0);
      wr(ECT_INTFLG_OFS, 32'h1);
      wr(ECT_CONTROL_A_OFS, 32'h1);
      pulse(4'h4);
      flag_is(1'b0);
      wr(ECT_EVCTRL_OFS, 32'h1);
      rd(ECT_CNT_OFS);
      a = rdv;
      ev_cnt = 0;
      pulse(4'h4);
      lat0 = t_out - t_rise;
      rd(ECT_CNT_OFS);
      b = rdv;
      flag_is(1'b1);
      chk("event_strobes", 32'h1, ev_cnt);
      rd(ECT_CAPTURE_COMPARE_VALUE_OFS);
      chk("capture_window", 32'h1, {31'h0, a <= rdv && rdv <= b});
      flag_is(1'b0);
      // falling edge selection
      wr(ECT_EVCTRL_OFS, 32'h11);
      base <= 1'b1;
      repeat (14) @(posedge pclk);
      flag_is(1'b0);
      base <= 1'b0;
      repeat (14) @(posedge pclk);
      flag_is(1'b1);
      rd(ECT_CAPTURE_COMPARE_VALUE_OFS);
      // filter with slow prescaler: short pulse lost, long one delayed by four
      wr(ECT_CONTROL_A_OFS, 32'hD);
      wr(ECT_EVCTRL_OFS, 32'h41);
      pulse(4'h3);
      flag_is(1'b0);
      pulse(4'h8);
      flag_is(1'b1);
      chk("filter_latency", 32'h4, (t_out - t_rise) - lat0);
      rd(ECT_CAPTURE_COMPARE_VALUE_OFS);
      // frequency: second capture holds only the short period
      wr(ECT_CONTROL_A_OFS, 32'h1);
      wr(ECT_CTRLB_OFS, 32'h3);
      wr(ECT_EVCTRL_OFS, 32'h1);
      pulse(4'h4);
      rd(ECT_CAPTURE_COMPARE_VALUE_OFS);
      pulse(4'h4);
      flag_is(1'b1);
      rd(ECT_CAPTURE_COMPARE_VALUE_OFS);
      chk("period_capture", 32'h1, {31'h0, rdv < 32'h28 && rdv != 32'h0});
      flag_is(1'b0);
      // time-out: restart, freeze, then restart into a near top
      wr(ECT_CONTROL_A_OFS, 32'h0);
      wr(ECT_CTRLB_OFS, 32'h1);
      wr(ECT_CAPTURE_COMPARE_VALUE_OFS, 32'hFFF0);
      wr(ECT_INTFLG_OFS, 32'h1);
      wr(ECT_CONTROL_A_OFS, 32'h1);
      pulse(4'h4);
      pulse(4'h4);
      rd(ECT_CNT_OFS);
      a = rdv;
      rd(ECT_CAPTURE_COMPARE_VALUE_OFS);
      rd(ECT_CNT_OFS);
      chk("frozen_count", a, rdv);
      flag_is(1'b0);
      wr(ECT_CAPTURE_COMPARE_VALUE_OFS, 32'h14);
      pulse(4'h4);
      repeat (30) @(posedge pclk);
      flag_is(1'b1);
      // companion clock: no tick, no count
      wr(ECT_CONTROL_A_OFS, 32'h0);
      wr(ECT_CTRLB_OFS, 32'h0);
      wr(ECT_CAPTURE_COMPARE_VALUE_OFS, 32'hFFFF);
      wr(ECT_CONTROL_A_OFS, 32'hF);
      rd(ECT_CNT_OFS);
      a = rdv;
      rd(ECT_CNT_OFS);
      b = rdv;
      chk("companion_idle", a, b);
      tick_en <= 1'b1;
      repeat (40) @(posedge pclk);
      rd(ECT_CNT_OFS);
      chk("companion_ticks", 32'h1, {31'h0, rdv > b});
      // wrap from max to bottom, top sitting at max as well
      wr(ECT_CONTROL_A_OFS, 32'h0);
      wr(ECT_CNT_OFS, 32'hFFFD);
      wr(ECT_CONTROL_A_OFS, 32'h1);
      repeat (4) @(posedge pclk);
      rd(ECT_CNT_OFS);
      chk("count_wrap", 32'h1, {31'h0, rdv < 32'h10});
      // reset in mid-run: mode and count back to reset values
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(ECT_CTRLB_OFS);
      chk("mode_after_rerun", 32'h0, rdv);
      rd(ECT_CNT_OFS);
      chk("count_after_rerun", 32'h0, rdv);
      complete_run();
   end
endmodule
